// File: reset_cause_regs.vh
`ifndef RESET_CAUSE_REGS_VH
`define RESET_CAUSE_REGS_VH

// register offsets (byte addresses on the APB)
`define FLAGS_OFFSET 8'h00
`define OSC_OFFSET 8'h04
`define IRQ_STATUS_OFFSET 8'h08
`define IRQ_MASK_OFFSET 8'h0c
`define SYS_STATUS_OFFSET 8'h10
`define START_ADDR_OFFSET 8'h14

// reset cause flag positions, and the interrupt status bit for a vector violation
`define TRAP_CONFLICT_BIT 15
`define ILLEGAL_OP_BIT 14
`define EXT_PIN_RESET_BIT 7
`define SOFTWARE_RESET_BIT 6
`define WATCHDOG_TIMEOUT_BIT 4
`define SLEEP_ENTERED_BIT 3
`define IDLE_ENTERED_BIT 2
`define BROWNOUT_BIT 1
`define POWER_ON_BIT 0
`define VECTOR_VIOLATION_BIT 5

// oscillator register fields
`define CUR_OSC_LSB 12
`define CUR_OSC_MSB 14
`define SWITCH_EN_BIT 7

// reset values and implemented bits
`define FLAGS_RESET 16'h0003
`define FLAGS_IMPL_MASK 16'hc0df
`define IRQ_IMPL_MASK 16'hc0ff
`define CUR_OSC_RESET 3'h0

// program memory vector area
`define RESET_VECTOR 24'h00_0000
`define START_WORD_ADDR 24'h00_0002
`define VECTOR_LIMIT 24'h00_0200

// timing
`define CLK_PERIOD_NS 50
`define POR_DELAY_NS 10000
// counts at the 50 ns clock, sized for the 21-bit timers
`define POR_DELAY_CYCLES 21'h0_00c8
`define POWER_UP_TIMER_DELAY_US 64000
`define POWER_UP_TIMER_DELAY_CYCLES 21'h13_8800

`endif

// File: delay_timer.v
`timescale 1ns/10ps
module delay_timer #(
   parameter [20:0] CYCLES = 21'd1
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // control
   input wire start,
   output reg done
);

   reg [20:0] count;

   // done rises CYCLES edges after the start pulse and then holds
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= 21'h0_0000;
         done <= 1'b0;
      end else if (start) begin
         count <= CYCLES;
         done <= 1'b0;
      end else if (count > 21'd1) begin
         count <= count - 21'd1;
      end else if (count == 21'd1) begin
         count <= 21'h0_0000;
         done <= 1'b1;
      end
   end

endmodule // delay_timer

// File: reset_cause_and_clock_select.v
// Overview of operation
// R1 - A trap conflict sets bit 15, and only a power-on or brown-out reset clears it in hardware.
// R2 - An illegal opcode or uninitialised register access sets bit 14, cleared by power-on or brown-out.
// R3 - A master-clear pin reset sets bit 7, and only a power-on reset clears it in hardware.
// R4 - A reset instruction sets bit 6, cleared by power-on or brown-out.
// R5 - A watchdog time-out sets bit 4, cleared by any power-save instruction, power-on or brown-out.
// R6 - A power-save instruction with the sleep operand sets bit 3, cleared by power-on or brown-out.
// R7 - A power-save instruction with the idle operand sets bit 2, cleared by power-on or brown-out.
// R8 - Brown-out or power-on sets bit 1, power-on sets bit 0, and no hardware event clears them.
// R9 - Software may set and clear every reset cause flag by writing the flag register.
// R10 - With clock switching off, reset always loads the clock source from the configuration bits.
// R11 - With switching on, power-on and brown-out load the new-oscillator field, other resets keep it.
// R12 - After reset the fetch starts at the reset vector, whose next word holds the start address.
// R13 - Addresses below the vector region limit are reserved and user code must not start there.
// R14 - The system reset is released only after both the power-on and power-up timer delays expire.
// R15 - A flag keeps its value across every event that is not one of its own set or clear events.
`timescale 1ns/10ps
`include "reset_cause_regs.vh"
module reset_cause_and_clock_select #(
   parameter [20:0] POWER_UP_TIMER_CYCLES = `POWER_UP_TIMER_DELAY_CYCLES
) (
   // clock and reset
   input wire MCLK,
   input wire RST,
   // apb slave
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output wire PREADY,
   output wire PSLVERR,
   output reg IRQ,
   // reset and power events, one-cycle pulses
   input wire POWER_ON_RESET,
   input wire BROWNOUT_RESET,
   input wire MASTER_CLEAR_PIN,
   input wire WATCHDOG_RESET,
   input wire SOFTWARE_RESET_INSTR,
   input wire TRAP_CONFLICT,
   input wire ILLEGAL_OP,
   input wire POWER_SAVE_SLEEP,
   input wire POWER_SAVE_IDLE,
   // oscillator selection
   input wire CLOCK_SWITCH_EN,
   input wire [2:0] NEW_OSCILLATOR_CONFIG,
   output reg [2:0] CURRENT_OSCILLATOR_BITS,
   // system reset and boot fetch
   output reg SYSTEM_RESET_SIGNAL,
   output reg FETCH_REQ,
   output reg [23:0] FETCH_ADDR,
   input wire [23:0] BOOT_WORD,
   output reg START_VALID,
   output reg [23:0] START_ADDR
);

   localparam [20:0] POR_CYCLES = `POR_DELAY_CYCLES;
   localparam [15:0] flags_impl = `FLAGS_IMPL_MASK;
   localparam [15:0] irq_impl = `IRQ_IMPL_MASK;

   // boot fetch states
   localparam [1:0] S_HOLD = 2'b00;
   localparam [1:0] S_GOTO = 2'b01;
   localparam [1:0] S_TARGET = 2'b10;
   localparam [1:0] S_RUN = 2'b11;

   // register state
   reg [15:0] flags;
   reg [15:0] irq_status;
   reg [15:0] irq_mask;
   reg [1:0] boot_state;
   reg por_pending;
   reg vector_violation;
   wire [15:0] next_flags;
   wire [15:0] next_irq_status;
   wire [15:0] next_irq_mask;
   reg [15:0] flag_set;
   reg [15:0] flag_clr;
   reg [15:0] irq_set;
   reg [31:0] read_data;
   reg mapped;

   // event and bus decode
   wire power_on;
   wire por_or_bor;
   wire power_save;
   wire reset_event;
   wire start_timers;
   wire por_done;
   wire power_up_timer_done;
   wire apb_setup;
   wire apb_write;
   wire wr_flags;
   wire wr_irq_status;
   wire wr_irq_mask;

   // the block reset counts as a power-on for the delay timers
   assign power_on = POWER_ON_RESET;
   assign por_or_bor = POWER_ON_RESET | BROWNOUT_RESET;
   assign power_save = POWER_SAVE_SLEEP | POWER_SAVE_IDLE;
   assign reset_event = por_or_bor | MASTER_CLEAR_PIN | WATCHDOG_RESET |
      SOFTWARE_RESET_INSTR | TRAP_CONFLICT | ILLEGAL_OP;
   assign start_timers = reset_event | por_pending;

   // apb: zero wait states, error only on unmapped access
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~mapped;
   assign apb_setup = PSEL & ~PENABLE;
   assign apb_write = PSEL & PENABLE & PWRITE;
   // writes commit in the access phase
   assign wr_flags = apb_write & (PADDR == `FLAGS_OFFSET);
   assign wr_irq_status = apb_write & (PADDR == `IRQ_STATUS_OFFSET);
   assign wr_irq_mask = apb_write & (PADDR == `IRQ_MASK_OFFSET);

   // set events of each cause flag
   always @* begin
      flag_set = 16'h0000;
      flag_set[`TRAP_CONFLICT_BIT] = TRAP_CONFLICT; // R1
      flag_set[`ILLEGAL_OP_BIT] = ILLEGAL_OP; // R2
      flag_set[`EXT_PIN_RESET_BIT] = MASTER_CLEAR_PIN; // R3
      flag_set[`SOFTWARE_RESET_BIT] = SOFTWARE_RESET_INSTR; // R4
      flag_set[`WATCHDOG_TIMEOUT_BIT] = WATCHDOG_RESET; // R5
      flag_set[`SLEEP_ENTERED_BIT] = POWER_SAVE_SLEEP; // R6
      flag_set[`IDLE_ENTERED_BIT] = POWER_SAVE_IDLE; // R7
      flag_set[`BROWNOUT_BIT] = por_or_bor; // R8
      flag_set[`POWER_ON_BIT] = power_on; // R8
   end

   // clear events; the two power flags have none
   always @* begin
      flag_clr = 16'h0000;
      flag_clr[`TRAP_CONFLICT_BIT] = por_or_bor; // R1
      flag_clr[`ILLEGAL_OP_BIT] = por_or_bor; // R2
      flag_clr[`EXT_PIN_RESET_BIT] = power_on; // R3
      flag_clr[`SOFTWARE_RESET_BIT] = por_or_bor; // R4
      flag_clr[`WATCHDOG_TIMEOUT_BIT] = power_save | por_or_bor; // R5
      flag_clr[`SLEEP_ENTERED_BIT] = por_or_bor; // R6
      flag_clr[`IDLE_ENTERED_BIT] = por_or_bor; // R7
   end

   // interrupt events follow the flag layout plus the vector check
   always @* begin
      irq_set = flag_set;
      irq_set[`VECTOR_VIOLATION_BIT] = vector_violation;
   end

   // per bit: set beats clear, clear beats a software write
   genvar i;
   generate
      for (i = 0; i < 16; i = i + 1) begin : g_bit
         assign next_flags[i] = ~flags_impl[i] ? 1'b0 :
            flag_set[i] ? 1'b1 : // R15
            flag_clr[i] ? 1'b0 :
            wr_flags ? PWDATA[i] : // R9
            flags[i]; // R15
         assign next_irq_status[i] = ~irq_impl[i] ? 1'b0 :
            irq_set[i] ? 1'b1 :
            (wr_irq_status & PWDATA[i]) ? 1'b0 :
            irq_status[i];
         // only implemented mask bits can be written
         assign next_irq_mask[i] = ~irq_impl[i] ? 1'b0 :
            wr_irq_mask ? PWDATA[i] :
            irq_mask[i];
      end
   endgenerate

   // cause flags, reset value marks a power-on
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         flags <= `FLAGS_RESET; // R8
      end else begin
         flags <= next_flags;
      end
   end

   // irq level follows a mask write at once, no lag
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         irq_status <= 16'h0000;
         irq_mask <= 16'h0000;
         IRQ <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         IRQ <= |(next_irq_status & next_irq_mask);
      end
   end

   // both delays run in parallel from the same start
   delay_timer #(
      .CYCLES(POR_CYCLES)
   ) u_por_delay (
      .clk(MCLK),
      .rst(RST),
      .start(start_timers),
      .done(por_done)
   );

   delay_timer #(
      .CYCLES(POWER_UP_TIMER_CYCLES)
   ) u_power_up_timer_delay (
      .clk(MCLK),
      .rst(RST),
      .start(start_timers),
      .done(power_up_timer_done)
   );

   // system reset: held from any cause until both delays ran out
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         por_pending <= 1'b1;
         SYSTEM_RESET_SIGNAL <= 1'b1;
      end else begin
         por_pending <= 1'b0;
         if (start_timers) begin
            SYSTEM_RESET_SIGNAL <= 1'b1;
         end else if (por_done & power_up_timer_done) begin
            SYSTEM_RESET_SIGNAL <= 1'b0; // R14
         end
      end
   end

   // clock source loaded from the config at each reset cause, except warm resets with switching on
   // the first edge after the block reset counts as a power-on
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         CURRENT_OSCILLATOR_BITS <= `CUR_OSC_RESET;
      end else if (start_timers) begin
         if (~CLOCK_SWITCH_EN) begin
            CURRENT_OSCILLATOR_BITS <= NEW_OSCILLATOR_CONFIG; // R10
         end else if (por_or_bor | por_pending) begin
            CURRENT_OSCILLATOR_BITS <= NEW_OSCILLATOR_CONFIG; // R11
         end else begin
            CURRENT_OSCILLATOR_BITS <= CURRENT_OSCILLATOR_BITS; // R11
         end
      end
   end

   // boot fetch: jump word at the vector, then the start address word
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         boot_state <= S_HOLD;
         FETCH_REQ <= 1'b0;
         FETCH_ADDR <= `RESET_VECTOR;
         START_VALID <= 1'b0;
         START_ADDR <= 24'h00_0000;
      end else begin
         if (start_timers) begin
            boot_state <= S_HOLD;
            FETCH_REQ <= 1'b0;
            FETCH_ADDR <= `RESET_VECTOR;
            START_VALID <= 1'b0;
         end else begin
            case (boot_state)
               S_HOLD: begin
                  if (~SYSTEM_RESET_SIGNAL) begin
                     boot_state <= S_GOTO;
                     FETCH_REQ <= 1'b1;
                     FETCH_ADDR <= `RESET_VECTOR; // R12
                  end
               end
               S_GOTO: begin
                  boot_state <= S_TARGET;
                  FETCH_ADDR <= `START_WORD_ADDR; // R12
               end
               S_TARGET: begin
                  // boot memory answers in the same cycle
                  boot_state <= S_RUN;
                  FETCH_REQ <= 1'b0;
                  START_ADDR <= BOOT_WORD; // R12
                  START_VALID <= 1'b1;
               end
               S_RUN: begin
                  // start address held until the next reset cause
                  boot_state <= S_RUN;
               end
               default: begin
                  boot_state <= S_HOLD;
                  FETCH_REQ <= 1'b0;
               end
            endcase
         end
      end
   end

   // start word inside the reserved vector area raises status bit 5
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         vector_violation <= 1'b0;
      end else begin
         vector_violation <= ~start_timers & (boot_state == S_TARGET) &
            (BOOT_WORD < `VECTOR_LIMIT); // R13
      end
   end

   // read mux and address decode
   always @* begin
      read_data = 32'h0000_0000;
      mapped = 1'b1;
      case (PADDR)
         `FLAGS_OFFSET: begin
            read_data[15:0] = flags;
         end
         // read-only views; writes there are ignored
         `OSC_OFFSET: begin
            read_data[`CUR_OSC_MSB:`CUR_OSC_LSB] = CURRENT_OSCILLATOR_BITS;
            read_data[`SWITCH_EN_BIT] = CLOCK_SWITCH_EN;
         end
         `IRQ_STATUS_OFFSET: begin
            read_data[15:0] = irq_status;
         end
         `IRQ_MASK_OFFSET: begin
            read_data[15:0] = irq_mask;
         end
         // timers and boot progress
         `SYS_STATUS_OFFSET: begin
            read_data[0] = SYSTEM_RESET_SIGNAL;
            read_data[1] = por_done;
            read_data[2] = power_up_timer_done;
            read_data[3] = START_VALID;
            read_data[5:4] = boot_state;
         end
         `START_ADDR_OFFSET: begin
            read_data[23:0] = START_ADDR;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // read data captured in the setup phase, held through access
   always @(posedge MCLK or posedge RST) begin
      if (RST) begin
         PRDATA <= 32'h0000_0000;
      end else if (apb_setup & ~PWRITE) begin
         PRDATA <= read_data;
      end
   end

endmodule // reset_cause_and_clock_select

// File: reset_cause_checker_assertions.sv
`timescale 1ns/10ps
module reset_cause_checker #(
   parameter [20:0] POWER_UP_TIMER_CYCLES = 21'h0_0014
) (
   // clock and reset
   input wire MCLK,
   input wire RST,
   // reset and power events
   input wire POWER_ON_RESET,
   input wire BROWNOUT_RESET,
   input wire MASTER_CLEAR_PIN,
   input wire WATCHDOG_RESET,
   input wire SOFTWARE_RESET_INSTR,
   input wire TRAP_CONFLICT,
   input wire ILLEGAL_OP,
   // oscillator, reset and boot fetch
   input wire CLOCK_SWITCH_EN,
   input wire [2:0] NEW_OSCILLATOR_CONFIG,
   input wire [2:0] CURRENT_OSCILLATOR_BITS,
   input wire SYSTEM_RESET_SIGNAL,
   input wire FETCH_REQ,
   input wire [23:0] FETCH_ADDR,
   input wire [23:0] BOOT_WORD,
   input wire START_VALID,
   input wire [23:0] START_ADDR
);
   localparam [20:0] HOLD = (POWER_UP_TIMER_CYCLES > 21'h0_00c8) ? POWER_UP_TIMER_CYCLES :
      21'h0_00c8;
   wire pb = POWER_ON_RESET | BROWNOUT_RESET;
   wire ev = pb | MASTER_CLEAR_PIN | WATCHDOG_RESET | SOFTWARE_RESET_INSTR |
      TRAP_CONFLICT | ILLEGAL_OP;
   reg [20:0] since;
   // cycles since the last reset event
   always @(posedge MCLK or posedge RST) begin
      if (RST)
         since <= 21'h0_0000;
      else if (ev)
         since <= 21'h0_0000;
      else if (since != 21'h1f_ffff)
         since <= since + 21'h0_0001;
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   sequence s_fetch;
      FETCH_REQ && FETCH_ADDR == 24'h00_0000 ##1
      FETCH_REQ && FETCH_ADDR == 24'h00_0002 ##1
      START_VALID && !FETCH_REQ && START_ADDR == $past(BOOT_WORD);
   endsequence
   property p_hold_on; ev |=> SYSTEM_RESET_SIGNAL [*8]; endproperty
   a_hold_on: assert property (p_hold_on)
      else $error("reset not held after event");
   property p_hold_min;
      $fell(SYSTEM_RESET_SIGNAL) |-> since >= HOLD - 21'h0_0001;
   endproperty
   a_hold_min: assert property (p_hold_min)
      else $error("reset released too early");
   property p_abort; ev |=> !FETCH_REQ && !START_VALID; endproperty
   a_abort: assert property (p_abort)
      else $error("fetch not aborted by reset");
   property p_fetch; $fell(SYSTEM_RESET_SIGNAL) |=> s_fetch; endproperty
   a_fetch: assert property (p_fetch)
      else $error("boot fetch sequence wrong");
   property p_start_hold;
      START_VALID && !ev |=> START_VALID && $stable(START_ADDR);
   endproperty
   a_start_hold: assert property (p_start_hold)
      else $error("start address not held");
   property p_osc_fixed;
      ev && !CLOCK_SWITCH_EN |=>
         CURRENT_OSCILLATOR_BITS == $past(NEW_OSCILLATOR_CONFIG);
   endproperty
   a_osc_fixed: assert property (p_osc_fixed)
      else $error("clock source not from config");
   property p_osc_new;
      pb |=> CURRENT_OSCILLATOR_BITS == $past(NEW_OSCILLATOR_CONFIG);
   endproperty
   a_osc_new: assert property (p_osc_new)
      else $error("power reset did not load config");
   property p_osc_keep;
      (MASTER_CLEAR_PIN | WATCHDOG_RESET | SOFTWARE_RESET_INSTR) &&
         CLOCK_SWITCH_EN && !pb |=> $stable(CURRENT_OSCILLATOR_BITS);
   endproperty
   a_osc_keep: assert property (p_osc_keep)
      else $error("clock source changed on warm reset");
endmodule // reset_cause_checker
bind reset_cause_and_clock_select reset_cause_checker #(
   .POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES)
) u_reset_cause_checker (
   .MCLK(MCLK), .RST(RST), .POWER_ON_RESET(POWER_ON_RESET),
   .BROWNOUT_RESET(BROWNOUT_RESET), .MASTER_CLEAR_PIN(MASTER_CLEAR_PIN),
   .WATCHDOG_RESET(WATCHDOG_RESET),
   .SOFTWARE_RESET_INSTR(SOFTWARE_RESET_INSTR),
   .TRAP_CONFLICT(TRAP_CONFLICT), .ILLEGAL_OP(ILLEGAL_OP),
   .CLOCK_SWITCH_EN(CLOCK_SWITCH_EN),
   .NEW_OSCILLATOR_CONFIG(NEW_OSCILLATOR_CONFIG),
   .CURRENT_OSCILLATOR_BITS(CURRENT_OSCILLATOR_BITS),
   .SYSTEM_RESET_SIGNAL(SYSTEM_RESET_SIGNAL), .FETCH_REQ(FETCH_REQ),
   .FETCH_ADDR(FETCH_ADDR), .BOOT_WORD(BOOT_WORD),
   .START_VALID(START_VALID), .START_ADDR(START_ADDR)
);

// File: reset_cause_and_clock_select_test.sv
`timescale 1ns/10ps
`include "reset_cause_regs.vh"
module reset_cause_and_clock_select_test;
   reg mclk, rst, psel, penable, pwrite, sw_en, err;
   reg [7:0] paddr;
   reg [31:0] pwdata, d;
   reg [8:0] ev, e;
   reg [2:0] cfg, osc;
   reg [23:0] st;
   reg [15:0] fl;
   wire [31:0] prdata;
   wire pready, pslverr, irq, sys_rst, fetch_req, start_valid;
   wire [2:0] cur;
   wire [23:0] fetch_addr, start_addr, boot_word;
   integer fails, tests_run, seed, i, cyc;
   assign boot_word = (fetch_addr == 24'h00_0002) ? st : 24'h04_0000;
   reset_cause_and_clock_select #(.POWER_UP_TIMER_CYCLES(21'h0_0014))
   u_reset_cause_and_clock_select (
      .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
      .POWER_ON_RESET(ev[0]), .BROWNOUT_RESET(ev[1]),
      .MASTER_CLEAR_PIN(ev[2]), .WATCHDOG_RESET(ev[3]),
      .SOFTWARE_RESET_INSTR(ev[4]), .TRAP_CONFLICT(ev[5]),
      .ILLEGAL_OP(ev[6]), .POWER_SAVE_SLEEP(ev[7]), .POWER_SAVE_IDLE(ev[8]),
      .CLOCK_SWITCH_EN(sw_en), .NEW_OSCILLATOR_CONFIG(cfg),
      .CURRENT_OSCILLATOR_BITS(cur), .SYSTEM_RESET_SIGNAL(sys_rst),
      .FETCH_REQ(fetch_req), .FETCH_ADDR(fetch_addr), .BOOT_WORD(boot_word),
      .START_VALID(start_valid), .START_ADDR(start_addr)
   );
   // flag register after one set of events
   function [15:0] nf(input [15:0] f, input [8:0] x);
      begin
         nf = f;
         if (x[0] | x[1])
            nf = nf & 16'h3fa3;
         if (x[0])
            nf[7] = 1'b0;
         if (x[7] | x[8])
            nf[4] = 1'b0;
         nf = nf | {x[5], x[6], 6'h00, x[2], x[4], 1'b0, x[3], x[7], x[8],
            x[1] | x[0], x[0]};
      end
   endfunction
   task check(input string nm, input [31:0] exp, input [31:0] got);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] wd);
      begin
         @(posedge mclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= wd;
         @(posedge mclk);
         penable <= 1'b1;
         @(posedge mclk);
         while (pready !== 1'b1) begin
            @(posedge mclk);
         end
         d = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wait_boot;
      begin
         repeat (2) @(posedge mclk);
         while (start_valid !== 1'b1) begin
            @(posedge mclk);
         end
      end
   endtask
   task results;
      begin
         $display("tests_run %0d fails %0d", tests_run, fails);
         if (fails == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         results;
      end
   end
   initial begin
      seed = 32'h02ea_75bf;
      {fails, tests_run, cyc} = 0;
      {rst, psel, penable, pwrite, sw_en} = 5'h10;
      {paddr, pwdata, ev} = 0;
      cfg = 3'h5;
      st = 24'h00_0400;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      fl = 16'h0003;
      osc = 3'h5;
      wait_boot;
      apb(1'b0, `FLAGS_OFFSET, 32'h0000_0000);
      check("flags", {16'h0000, fl}, d);
      apb(1'b0, 8'h18, 32'h0000_0000);
      check("slverr", 32'h0000_0001, {31'h0, err});
      apb(1'b1, `IRQ_MASK_OFFSET, 32'h0000_0030);
      apb(1'b0, `IRQ_MASK_OFFSET, 32'h0000_0000);
      check("mask", 32'h0000_0030, d);
      for (i = 0; i < 24; i = i + 1) begin
         d = $random(seed);
         sw_en <= d[0];
         cfg <= d[3:1];
         st <= (i % 4 == 1) ? 24'h00_01fe : (i % 4 == 2) ? 24'h00_0200 :
            (d[23:0] | 24'h00_0200);
         d = $random(seed);
         fl = d[15:0] & `FLAGS_IMPL_MASK;
         apb(1'b1, `FLAGS_OFFSET, d);
         apb(1'b0, `FLAGS_OFFSET, 32'h0000_0000);
         check("flags wr", {16'h0000, fl}, d);
         d = $random(seed);
         e = (i < 9) ? 9'h001 << i : (i == 9) ? 9'h005 :
            d[8:0] & d[17:9] & d[26:18];
         @(posedge mclk);
         ev <= e;
         @(posedge mclk);
         ev <= 9'h000;
         fl = nf(fl, e);
         if (|e[6:0]) begin
            if (!sw_en || e[0] || e[1])
               osc = cfg;
            wait_boot;
            check("start", {8'h00, st}, {8'h00, start_addr});
            apb(1'b0, `START_ADDR_OFFSET, 32'h0000_0000);
            check("start reg", {8'h00, st}, d);
            apb(1'b0, `SYS_STATUS_OFFSET, 32'h0000_0000);
            check("sys status", 32'h0000_003e, d);
         end
         apb(1'b0, `FLAGS_OFFSET, 32'h0000_0000);
         check("flags", {16'h0000, fl}, d);
         apb(1'b0, `OSC_OFFSET, 32'h0000_0000);
         check("osc", {17'h0, osc, 4'h0, sw_en, 7'h0}, d);
         check("irq", {31'h0, e[3] | (|e[6:0] && st < `VECTOR_LIMIT)},
            {31'h0, irq});
         apb(1'b1, `IRQ_STATUS_OFFSET, 32'h0000_ffff);
         apb(1'b0, `IRQ_STATUS_OFFSET, 32'h0000_0000);
         check("irq clr", 32'h0000_0000, {d[31:1], irq});
      end
      results;
   end
endmodule // reset_cause_and_clock_select_test
